/* File: hdl/ctlc_pkg.sv */
// constants shared by the carrier timer link control block
package ctlc_pkg;
    // register offsets (8-bit address, 8-bit data)
    localparam logic [7:0] OFS_LINK_CTRL  = 8'h01;
    localparam logic [7:0] OFS_SHORT_CTRL = 8'h02;
    localparam logic [7:0] OFS_SHORT_HI   = 8'h03;
    localparam logic [7:0] OFS_SHORT_LO   = 8'h04;
    localparam logic [7:0] OFS_LONG_CTRL  = 8'h05;
    localparam logic [7:0] OFS_LONG_HI    = 8'h06;
    localparam logic [7:0] OFS_LONG_LO    = 8'h07;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h09;

    // link control fields
    localparam int BIT_MODE      = 7;
    localparam int BIT_PIN_SEL   = 6;
    localparam int FLD_LOGIC_HI  = 5;
    localparam int FLD_LOGIC_LO  = 4;
    localparam int FLD_OUT_HI    = 3;
    localparam int FLD_OUT_LO    = 2;
    localparam int BIT_SHORT_INI = 1;
    localparam int BIT_LONG_INI  = 0;

    // timer control fields
    localparam int BIT_TMR_EN     = 7;
    localparam int BIT_TMR_SINGLE = 6;

    // interrupt status bits
    localparam int IRQ_SHORT_TC = 0;
    localparam int IRQ_LONG_TC  = 1;
    localparam int IRQ_FALL     = 2;
    localparam int IRQ_RISE     = 3;

    localparam logic [7:0] LINK_CTRL_RST = 8'h00;
    localparam logic [7:0] TMR_RST       = 8'h00;
    localparam logic [3:0] IRQ_RST       = 4'h0;

    // combining logic codes
    localparam logic [1:0] LOGIC_AND  = 2'h0;
    localparam logic [1:0] LOGIC_OR   = 2'h1;
    localparam logic [1:0] LOGIC_NOR  = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;

    // output behaviour codes
    localparam logic [1:0] OUT_NORMAL   = 2'h0;
    localparam logic [1:0] OUT_PINGPONG = 2'h1;
    localparam logic [1:0] OUT_FORCE_LO = 2'h2;
    localparam logic [1:0] OUT_FORCE_HI = 2'h3;

    // demodulator edge and filter codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_4    = 2'h1;
    localparam logic [1:0] FILT_8    = 2'h2;
    localparam logic [3:0] FILT_4_CYCLES = 4'h4;
    localparam logic [3:0] FILT_8_CYCLES = 4'h8;

    localparam int SCLK_DIV_DEFAULT = 2;
endpackage : ctlc_pkg

/* File: hdl/ctlc_tmr_if.sv */
// signals between the control core and the timer pair
`timescale 1ns/1ps
interface ctlc_tmr_if;
    logic        start_short;
    logic        stop_short;
    logic        start_long;
    logic        stop_long;
    logic        single_short;
    logic        single_long;
    logic        pingpong;
    logic        init_short;
    logic        init_long;
    logic [7:0]  short_hi;
    logic [7:0]  short_lo;
    logic [15:0] long_reload;
    logic        short_out;
    logic        long_out;
    logic        short_en;
    logic        long_en;
    logic        short_tc;
    logic        long_tc;

    modport core (output start_short, stop_short, start_long, stop_long, single_short,
                  single_long, pingpong, init_short, init_long, short_hi, short_lo,
                  long_reload, input short_out, long_out, short_en, long_en, short_tc,
                  long_tc);
    modport timers (input start_short, stop_short, start_long, stop_long, single_short,
                    single_long, pingpong, init_short, init_long, short_hi, short_lo,
                    long_reload, output short_out, long_out, short_en, long_en, short_tc,
                    long_tc);
endinterface : ctlc_tmr_if

/* File: hdl/ctlc_timers.sv */
// short and long down-counting timers with ping-pong hand-over
`timescale 1ns/1ps
module ctlc_timers
    import ctlc_pkg::*;
(
    input wire logic     clk,
    input wire logic     reset_n,
    ctlc_tmr_if.timers   tif
);
    logic [7:0]  cnt_s_q;
    logic [15:0] cnt_l_q;
    logic        out_s_q;
    logic        out_l_q;
    logic        en_s_q;
    logic        en_l_q;
    logic        tc_s;
    logic        tc_l;
    logic        go_s;
    logic        go_l;
    logic        halt_s;
    logic        halt_l;

    assign tc_s   = en_s_q && (cnt_s_q == 8'h00);
    assign tc_l   = en_l_q && (cnt_l_q == 16'h0000);
    // in ping-pong mode each terminal count hands the pair over to the other timer
    assign go_s   = tif.start_short || (tif.pingpong && tc_l);
    assign go_l   = tif.start_long || (tif.pingpong && tc_s);
    assign halt_s = tif.stop_short || (tc_s && (tif.single_short || tif.pingpong));
    assign halt_l = tif.stop_long || (tc_l && (tif.single_long || tif.pingpong));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_s_q <= 1'b0;
            en_l_q <= 1'b0;
        end else begin
            if (go_s) begin
                en_s_q <= 1'b1;
            end else if (halt_s) begin
                en_s_q <= 1'b0;
            end
            if (go_l) begin
                en_l_q <= 1'b1;
            end else if (halt_l) begin
                en_l_q <= 1'b0;
            end
        end
    end

    // start level chooses which half-period value is loaded first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_s_q <= 1'b0;
            cnt_s_q <= 8'h00;
        end else if (go_s) begin
            out_s_q <= tif.init_short;
            cnt_s_q <= tif.init_short ? tif.short_hi : tif.short_lo;
        end else if (tc_s) begin
            out_s_q <= ~out_s_q;
            cnt_s_q <= out_s_q ? tif.short_lo : tif.short_hi;
        end else if (en_s_q) begin
            cnt_s_q <= cnt_s_q - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_l_q <= 1'b0;
            cnt_l_q <= 16'h0000;
        end else if (go_l) begin
            out_l_q <= tif.init_long;
            cnt_l_q <= tif.long_reload;
        end else if (tc_l) begin
            out_l_q <= ~out_l_q;
            cnt_l_q <= tif.long_reload;
        end else if (en_l_q) begin
            cnt_l_q <= cnt_l_q - 16'h0001;
        end
    end

    assign tif.short_out = out_s_q;
    assign tif.long_out  = out_l_q;
    assign tif.short_en  = en_s_q;
    assign tif.long_en   = en_l_q;
    assign tif.short_tc  = tc_s;
    assign tif.long_tc   = tc_l;
endmodule : ctlc_timers

/* File: hdl/ctlc_demod.sv */
// demodulator input select, noise filter and edge detection
`timescale 1ns/1ps
module ctlc_demod
    import ctlc_pkg::*;
#(
    parameter int SCLK_DIV = SCLK_DIV_DEFAULT
)(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       port_three_demod_input,
    input  wire logic       port_two_demod_input,
    input  wire logic       demod_on,
    input  wire logic       sel_port_two,
    input  wire logic [1:0] filter_sel,
    input  wire logic [1:0] edge_sel,
    output logic            fall_evt,
    output logic            rise_evt
);
    logic [1:0] sync3_q;
    logic [1:0] sync2_q;
    logic [7:0] pre_q;
    logic [3:0] stab_q;
    logic       filt_q;
    logic       prev_q;
    logic       raw;
    logic       tick;
    logic [3:0] need;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync3_q <= 2'h0;
            sync2_q <= 2'h0;
        end else begin
            sync3_q <= {sync3_q[0], port_three_demod_input};
            sync2_q <= {sync2_q[0], port_two_demod_input};
        end
    end

    assign raw  = sel_port_two ? sync2_q[1] : sync3_q[1];
    assign tick = (pre_q == 8'(SCLK_DIV - 1));
    // reserved filter code acts as no filter
    assign need = (filter_sel == FILT_4) ? FILT_4_CYCLES :
                  (filter_sel == FILT_8) ? FILT_8_CYCLES : 4'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= tick ? 8'h00 : pre_q + 8'h01;
        end
    end

    // a change passes only after staying put for need scaled-clock ticks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_q <= 1'b0;
            stab_q <= 4'h0;
        end else if (need == 4'h0 || raw == filt_q) begin
            filt_q <= raw;
            stab_q <= 4'h0;
        end else if (tick) begin
            if (stab_q + 4'h1 >= need) begin
                filt_q <= raw;
                stab_q <= 4'h0;
            end else begin
                stab_q <= stab_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q   <= 1'b0;
            fall_evt <= 1'b0;
            rise_evt <= 1'b0;
        end else begin
            prev_q   <= filt_q;
            fall_evt <= demod_on && prev_q && !filt_q
                        && (edge_sel != EDGE_RISE);
            rise_evt <= demod_on && !prev_q && filt_q
                        && (edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH);
        end
    end
endmodule : ctlc_demod

/* File: hdl/ctlc_top.sv */
// carrier timer link control: register port, output combining, demod flags
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module ctlc_top
    import ctlc_pkg::*;
#(
    parameter int SCLK_DIV = SCLK_DIV_DEFAULT
)(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       stop_recovery,
    input  wire logic       port_out_data,
    input  wire logic       port_three_demod_input,
    input  wire logic       port_two_demod_input,
    output logic            carrier_output_pin,
    output logic            carrier_output_timer_sel,
    output logic            irq
);
    logic [7:0]  ctrl_q;
    logic        flag_fall_q;
    logic        flag_rise_q;
    logic [7:0]  short_ctrl_q;
    logic [7:0]  short_hi_q;
    logic [7:0]  short_lo_q;
    logic [7:0]  long_ctrl_q;
    logic [7:0]  long_hi_q;
    logic [7:0]  long_lo_q;
    logic [3:0]  stat_q;
    logic [3:0]  mask_q;
    logic        demod;
    logic        tx;
    logic        long_eff;
    logic        fall_evt;
    logic        rise_evt;
    logic        wr_ctrl;
    logic [3:0]  stat_set;
    logic [7:0]  rd_d;

    ctlc_tmr_if tif ();

    function automatic logic ctlc_combine(input logic a, input logic b, input logic [1:0] op);
        case (op)
            LOGIC_AND:  ctlc_combine = a & b;
            LOGIC_OR:   ctlc_combine = a | b;
            LOGIC_NOR:  ctlc_combine = ~(a | b);
            default:    ctlc_combine = ~(a & b);
        endcase
    endfunction : ctlc_combine

    assign demod   = ctrl_q[BIT_MODE];
    assign tx      = ~demod;
    assign wr_ctrl = reg_wr && (reg_addr == OFS_LINK_CTRL);

    // link control; stop recovery restores defaults except the logic field
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= LINK_CTRL_RST;
        end else if (stop_recovery) begin
            ctrl_q[7:6] <= LINK_CTRL_RST[7:6];
            ctrl_q[3:0] <= LINK_CTRL_RST[3:0];
        end else if (wr_ctrl) begin
            ctrl_q[7:2] <= reg_wdata[7:2];
            // start levels only change on a transmit-mode write
            if (!reg_wdata[BIT_MODE]) begin
                ctrl_q[1:0] <= reg_wdata[1:0];
            end
        end
    end

    // edge flags: a new edge wins over a simultaneous clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_fall_q <= 1'b0;
            flag_rise_q <= 1'b0;
        end else begin
            if (fall_evt) begin
                flag_fall_q <= 1'b1;
            end else if (wr_ctrl && reg_wdata[BIT_MODE] && reg_wdata[BIT_LONG_INI]) begin
                flag_fall_q <= 1'b0;
            end
            if (rise_evt) begin
                flag_rise_q <= 1'b1;
            end else if (wr_ctrl && reg_wdata[BIT_MODE] && reg_wdata[BIT_SHORT_INI]) begin
                flag_rise_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            short_ctrl_q <= TMR_RST;
            short_hi_q   <= TMR_RST;
            short_lo_q   <= TMR_RST;
            long_ctrl_q  <= TMR_RST;
            long_hi_q    <= TMR_RST;
            long_lo_q    <= TMR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_SHORT_CTRL: short_ctrl_q <= reg_wdata;
                OFS_SHORT_HI:   short_hi_q   <= reg_wdata;
                OFS_SHORT_LO:   short_lo_q   <= reg_wdata;
                OFS_LONG_CTRL:  long_ctrl_q  <= reg_wdata;
                OFS_LONG_HI:    long_hi_q    <= reg_wdata;
                OFS_LONG_LO:    long_lo_q    <= reg_wdata;
                default:        ;
            endcase
        end
    end

    // enables are pulses; the live enable state lives in the timers
    assign tif.start_short  = reg_wr && reg_addr == OFS_SHORT_CTRL && reg_wdata[BIT_TMR_EN];
    assign tif.stop_short   = reg_wr && reg_addr == OFS_SHORT_CTRL && !reg_wdata[BIT_TMR_EN];
    assign tif.start_long   = reg_wr && reg_addr == OFS_LONG_CTRL && reg_wdata[BIT_TMR_EN];
    assign tif.stop_long    = reg_wr && reg_addr == OFS_LONG_CTRL && !reg_wdata[BIT_TMR_EN];
    assign tif.single_short = short_ctrl_q[BIT_TMR_SINGLE];
    assign tif.single_long  = long_ctrl_q[BIT_TMR_SINGLE];
    assign tif.pingpong     = tx && (ctrl_q[FLD_OUT_HI:FLD_OUT_LO] == OUT_PINGPONG);
    assign tif.init_short   = ctrl_q[BIT_SHORT_INI];
    assign tif.init_long    = ctrl_q[BIT_LONG_INI];
    assign tif.short_hi     = short_hi_q;
    assign tif.short_lo     = short_lo_q;
    assign tif.long_reload  = {long_hi_q, long_lo_q};

    ctlc_timers u_timers (
        .clk     (clk),
        .reset_n (reset_n),
        .tif     (tif.timers)
    );

    ctlc_demod #(
        .SCLK_DIV (SCLK_DIV)
    ) u_demod (
        .clk                    (clk),
        .reset_n                (reset_n),
        .port_three_demod_input (port_three_demod_input),
        .port_two_demod_input   (port_two_demod_input),
        .demod_on               (demod),
        .sel_port_two           (ctrl_q[BIT_PIN_SEL]),
        .filter_sel             (ctrl_q[FLD_OUT_HI:FLD_OUT_LO]),
        .edge_sel               (ctrl_q[FLD_LOGIC_HI:FLD_LOGIC_LO]),
        .fall_evt               (fall_evt),
        .rise_evt               (rise_evt)
    );

    // forced codes override the long timer level at the combiner
    always_comb begin
        case (ctrl_q[FLD_OUT_HI:FLD_OUT_LO])
            OUT_FORCE_LO: long_eff = 1'b0;
            OUT_FORCE_HI: long_eff = 1'b1;
            default:      long_eff = tif.long_out;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            carrier_output_pin       <= 1'b0;
            carrier_output_timer_sel <= 1'b0;
        end else begin
            carrier_output_timer_sel <= tx && ctrl_q[BIT_PIN_SEL];
            if (tx && ctrl_q[BIT_PIN_SEL]) begin
                carrier_output_pin <= ctlc_combine(tif.short_out, long_eff,
                                                   ctrl_q[FLD_LOGIC_HI:FLD_LOGIC_LO]);
            end else begin
                carrier_output_pin <= port_out_data;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    assign stat_set = {rise_evt, fall_evt, tif.long_tc, tif.short_tc};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
            irq    <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
                stat_q <= (stat_q & ~reg_wdata[3:0]) | stat_set;
            end else begin
                stat_q <= stat_q | stat_set;
            end
            if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
                mask_q <= reg_wdata[3:0];
            end
            irq <= |(stat_q & mask_q);
        end
    end

    // demod mode shows the edge flags in the start-level bits
    always_comb begin
        case (reg_addr)
            OFS_LINK_CTRL:  rd_d = demod ? {ctrl_q[7:2], flag_rise_q, flag_fall_q} : ctrl_q;
            OFS_SHORT_CTRL: rd_d = {tif.short_en, short_ctrl_q[6:0]};
            OFS_SHORT_HI:   rd_d = short_hi_q;
            OFS_SHORT_LO:   rd_d = short_lo_q;
            OFS_LONG_CTRL:  rd_d = {tif.long_en, long_ctrl_q[6:0]};
            OFS_LONG_HI:    rd_d = long_hi_q;
            OFS_LONG_LO:    rd_d = long_lo_q;
            OFS_IRQ_STAT:   rd_d = {4'h0, stat_q};
            OFS_IRQ_MASK:   rd_d = {4'h0, mask_q};
            default:        rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_d : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_TX_PORT_PIN: assert property (
        (tx && !ctrl_q[BIT_PIN_SEL]) |=> carrier_output_pin == $past(port_out_data))
        else $error("pin not following port latch in transmit mode");
    AST_NAND_COMBINE: assert property (
        (tx && ctrl_q[BIT_PIN_SEL] && ctrl_q[5:4] == LOGIC_NAND) |=>
            carrier_output_pin == !($past(tif.short_out) && $past(long_eff)))
        else $error("NAND combination wrong");
    AST_FORCE_HIGH: assert property (
        (tx && ctrl_q[7:2] == 6'h17) |=> carrier_output_pin == 1'b1)
        else $error("forced-high OR output not high");
    AST_FALL_SET: assert property (
        fall_evt |=> flag_fall_q)
        else $error("falling edge flag not set");
    AST_RISE_CLEAR: assert property (
        (wr_ctrl && reg_wdata[7] && reg_wdata[1] && !rise_evt) |=> !flag_rise_q)
        else $error("rising edge flag not cleared by write of one");
    AST_FLAG_WRITE_ZERO: assert property (
        (flag_fall_q && wr_ctrl && !reg_wdata[0]) |=> flag_fall_q)
        else $error("write of zero cleared falling flag");
    AST_STOP_KEEPS_LOGIC: assert property (
        stop_recovery |=> ctrl_q[5:4] == $past(ctrl_q[5:4]) && !ctrl_q[7])
        else $error("stop recovery disturbed logic field or mode");
    AST_PP_HANDOFF: assert property (
        (tif.pingpong && tif.short_tc && !tif.start_short && !tif.long_tc) |=>
            tif.long_en && !tif.short_en)
        else $error("ping-pong hand-over from short timer failed");
    AST_IRQ_LEVEL: assert property (
        (stat_q & mask_q) != 4'h0 |=> irq)
        else $error("interrupt not raised");

    // mode, pin, start-level, edge-select, ping-pong hand-over and status checks
    AST_FORCE_LOW: assert property (
        (tx && ctrl_q[BIT_PIN_SEL] && ctrl_q[5:2] == 4'h2) |=> carrier_output_pin == 1'b0)
        else $error("forced-low AND output not low");
    AST_TIMER_SEL: assert property (
        (tx && ctrl_q[BIT_PIN_SEL]) |=> carrier_output_timer_sel)
        else $error("pin not handed to the timers");
    AST_DEMOD_PIN: assert property (
        demod |=> !carrier_output_timer_sel && carrier_output_pin == $past(port_out_data))
        else $error("timer output on pin in demodulation mode");
    AST_START_LEVEL_WR: assert property (
        (wr_ctrl && !reg_wdata[BIT_MODE] && !stop_recovery) |=>
            ctrl_q[1:0] == $past(reg_wdata[1:0]))
        else $error("start levels not stored");
    AST_DEMOD_KEEPS_LEVELS: assert property (
        (wr_ctrl && reg_wdata[BIT_MODE] && !stop_recovery) |=>
            ctrl_q[1:0] == $past(ctrl_q[1:0]))
        else $error("demodulation write changed start levels");
    AST_TX_NO_EDGE: assert property (
        !demod |=> !fall_evt && !rise_evt)
        else $error("edge event in transmit mode");
    AST_RISE_SEL: assert property (
        (ctrl_q[5:4] == EDGE_FALL || ctrl_q[5:4] == 2'h3) |=> !rise_evt)
        else $error("rising edge taken while not selected");
    AST_FALL_SEL: assert property (
        ctrl_q[5:4] == EDGE_RISE |=> !fall_evt)
        else $error("falling edge taken while not selected");
    AST_PP_RESTART: assert property (
        (tif.pingpong && tif.long_tc && !tif.short_tc && !tif.start_long) |=>
            tif.short_en && !tif.long_en)
        else $error("ping-pong hand-over from long timer failed");
    AST_STAT_STICKY: assert property (
        (stat_q[IRQ_FALL] && !(reg_wr && reg_addr == OFS_IRQ_STAT)) |=> stat_q[IRQ_FALL])
        else $error("status bit dropped without a clear");

    COV_PINGPONG: cover property (tif.pingpong && tif.long_tc ##1 tif.short_en);
    COV_FALL_FLAG: cover property (fall_evt ##1 flag_fall_q);
    COV_RISE_FILTERED: cover property (demod && ctrl_q[3:2] == FILT_8 && rise_evt);
    COV_FALL_FILTERED: cover property (demod && ctrl_q[3:2] == FILT_4 && fall_evt);
    COV_STOP_KEEP: cover property (stop_recovery ##1 ctrl_q[5:4] == LOGIC_NAND);
endmodule : ctlc_top

/* File: testbench/ctlc_far_model.sv */
// far-side pin model: drives the demodulator inputs, counts carrier pin toggles
`timescale 1ns/1ps
module ctlc_far_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       carrier_output_pin,
    input  wire logic [1:0] lvl,
    output logic            port_three_demod_input,
    output logic            port_two_demod_input,
    output logic      [7:0] pin_toggles
);
    logic last_q;

    // receiver comparator output, launched on the clock so the bench stays race free
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_three_demod_input <= 1'b0;
            port_two_demod_input   <= 1'b0;
            last_q                 <= 1'b0;
            pin_toggles            <= 8'h00;
        end else begin
            port_three_demod_input <= lvl[0];
            port_two_demod_input   <= lvl[1];
            last_q                 <= carrier_output_pin;
            if (last_q != carrier_output_pin) begin
                pin_toggles <= pin_toggles + 8'h01;
            end
        end
    end
endmodule : ctlc_far_model

/* File: testbench/tb_top.sv */
// self-checking testbench for the carrier timer link control block
`timescale 1ns/1ps
module tb_top import ctlc_pkg::*; ();
    logic       clk, reset_n, reg_wr, reg_rd, stop_recovery, port_out_data, irq;
    logic       port_three_demod_input, port_two_demod_input;
    logic       carrier_output_pin, carrier_output_timer_sel;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, pin_toggles;
    logic [1:0] lvl;
    int         miscompares = 0;
    int         total_checks = 0;

    // scaled clock equal to clk keeps filter counts short
    ctlc_top #(.SCLK_DIV(1)) u_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .stop_recovery, .port_out_data, .port_three_demod_input,
        .port_two_demod_input, .carrier_output_pin, .carrier_output_timer_sel, .irq);
    ctlc_far_model u_far (.clk, .reset_n, .carrier_output_pin, .lvl,
        .port_three_demod_input, .port_two_demod_input, .pin_toggles);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task summarize;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // pulse one far-side input: hi cycles up, then lo cycles idle
    task pin(input int b, input int hi, input int lo);
        lvl[b] <= 1'b1;
        cyc(hi);
        lvl[b] <= 1'b0;
        cyc(lo);
    endtask : pin

    task t_combine;
        logic e;
        rd(OFS_LINK_CTRL);
        chk("ctrl_rst", d, LINK_CTRL_RST);
        rd(8'h0A);
        chk("unmapped", d, 8'h00);
        cyc(1);
        port_out_data <= 1'b1;
        cyc(3);
        chk("port_pin", {7'h0, carrier_output_pin}, 8'h01);
        wr(OFS_SHORT_HI, 8'hFF);
        wr(OFS_LINK_CTRL, 8'h42);
        wr(OFS_SHORT_CTRL, 8'h80);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_LINK_CTRL, {2'b01, 2'(k >> 1), 1'b1, k[0], 2'b10});
            cyc(3);
            e = (k < 2) ? k[0] : (k < 4) ? 1'b1 : (k < 6) ? 1'b0 : !k[0];
            chk("combine", {7'h0, carrier_output_pin}, {7'h0, e});
        end
        chk("timer_sel", {7'h0, carrier_output_timer_sel}, 8'h01);
        chk("toggles", {7'h0, |pin_toggles}, 8'h01);
        $display("done combine");
    endtask : t_combine

    task t_pingpong;
        wr(OFS_SHORT_CTRL, 8'h40);
        wr(OFS_LONG_CTRL, 8'h40);
        wr(OFS_IRQ_STAT, 8'h0F);
        wr(OFS_SHORT_LO, 8'h02);
        wr(OFS_LONG_HI, 8'h00);
        wr(OFS_LONG_LO, 8'h28);
        wr(OFS_LINK_CTRL, 8'h44);
        wr(OFS_SHORT_CTRL, 8'hC0);
        cyc(6);
        rd(OFS_SHORT_CTRL);
        chk("short_off", d, 8'h40);
        rd(OFS_LONG_CTRL);
        chk("long_on", d, 8'hC0);
        rd(OFS_IRQ_STAT);
        chk("short_tc", d, 8'h01);
        cyc(36);
        rd(OFS_IRQ_STAT);
        chk("long_tc", d, 8'h03);
        rd(OFS_LONG_CTRL);
        chk("long_again", d, 8'hC0);
        wr(OFS_LINK_CTRL, 8'h00);
        wr(OFS_LONG_CTRL, 8'h00);
        $display("done pingpong");
    endtask : t_pingpong

    task t_demod;
        wr(OFS_IRQ_MASK, 8'h04);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_LINK_CTRL, 8'h83 | 8'(e << 4));
            pin(0, 12, 12);
            rd(OFS_LINK_CTRL);
            chk("edges", d, {2'b10, 2'(e), 2'b00, e == 1 || e == 2, e != 1});
        end
        chk("irq_on", {7'h0, irq}, 8'h01);
        wr(OFS_IRQ_STAT, 8'h04);
        cyc(2);
        chk("irq_off", {7'h0, irq}, 8'h00);
        wr(OFS_LINK_CTRL, 8'h80);
        rd(OFS_LINK_CTRL);
        chk("w0_keep", d, 8'h81);
        wr(OFS_LINK_CTRL, 8'h81);
        rd(OFS_LINK_CTRL);
        chk("w1_clear", d, 8'h80);
        wr(OFS_LINK_CTRL, 8'hC3);
        pin(0, 12, 12);
        rd(OFS_LINK_CTRL);
        chk("sel_three", d, 8'hC0);
        pin(1, 12, 12);
        rd(OFS_LINK_CTRL);
        chk("sel_two", d, 8'hC1);
        $display("done demod");
    endtask : t_demod

    task t_filter;
        for (int f = 1; f < 4; f++) begin
            wr(OFS_LINK_CTRL, 8'h83 | 8'(f << 2));
            pin(0, 4 * f - 2, 24);
            rd(OFS_LINK_CTRL);
            chk("short_pulse", d, 8'h80 | 8'(f << 2) | 8'(f == 3));
            pin(0, 4 * f + 8, 24);
            rd(OFS_LINK_CTRL);
            chk("long_pulse", d, 8'h81 | 8'(f << 2));
        end
        wr(OFS_LINK_CTRL, 8'h3F);
        stop_recovery <= 1'b1;
        @(posedge clk);
        stop_recovery <= 1'b0;
        rd(OFS_LINK_CTRL);
        chk("stop_keep", d, 8'h30);
        $display("done filter");
    endtask : t_filter

    initial begin
        reset_n       = 1'b0;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
        stop_recovery = 1'b0;
        port_out_data = 1'b0;
        lvl           = 2'h0;
        cyc(12);
        reset_n <= 1'b1;
        t_combine;
        t_pingpong;
        t_demod;
        t_filter;
        summarize;
    end

    // hang guard, far beyond the longest scenario
    initial begin
        cyc(20000);
        miscompares++;
        summarize;
    end
endmodule : tb_top
